// ==== design/fepipe_pkg.sv ====
// Constants and types shared by the fetch/execute pipeline sequencer
package fepipe_pkg;
   localparam int unsigned FEPIPE_PC_W = 15;
   localparam int unsigned FEPIPE_INSN_W = 16;
   localparam logic [FEPIPE_PC_W-1:0] FEPIPE_RESET_VECTOR = 15'h0000;
   localparam int unsigned FEPIPE_PHASES = 4;
   localparam int unsigned FEPIPE_PAGE_W = 8;
   // Start-up counts in system clock periods
   localparam int unsigned FEPIPE_SST_XTAL = 1024;
   localparam int unsigned FEPIPE_SST_RC_SHORT = 2;
   localparam int unsigned FEPIPE_SST_RC_LONG = 1024;
   localparam int unsigned FEPIPE_SST_W = 11;
   typedef enum logic [1:0] {
      FEPIPE_SRC_XTAL,
      FEPIPE_SRC_RC_SHORT,
      FEPIPE_SRC_RC_LONG,
      FEPIPE_SRC_RSVD
   } fepipe_src_t;
endpackage : fepipe_pkg

// ==== design/fepipe_phase_gen.sv ====
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`default_nettype none
module fepipe_phase_gen
   import fepipe_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   input wire logic run,
   output logic [FEPIPE_PHASES-1:0] instruction_phase_clocks
);
   typedef struct packed {
      logic [FEPIPE_PHASES-1:0] ring;
   } fepipe_ph_state_t;
   fepipe_ph_state_t state;
   fepipe_ph_state_t next_state;

   always_comb begin
      next_state = state;
      if (!run) begin
         next_state.ring = '0;
      end else if (state.ring == '0) begin
         next_state.ring = 4'h1;
      end else begin
         // One-hot rotation keeps phases non-overlapping
         next_state.ring = {state.ring[FEPIPE_PHASES-2:0], state.ring[FEPIPE_PHASES-1]};
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= '0;
      end else if (clock_enable) begin
         state <= next_state;
      end
   end

   assign instruction_phase_clocks = state.ring;
endmodule : fepipe_phase_gen
`default_nettype wire

// ==== design/fepipe_top.sv ====
// Fetch/execute pipeline sequencer for a small 8-bit core
// Behaviour
// - Four non-overlapping one-hot phases; one full pass is one instruction cycle.
// - Program counter advances at end of phase one, new word fetched in phase two.
// - Phases two to four decode and execute the previously fetched word.
// - Fetch of next word overlaps execution, one instruction per cycle.
// - Instructions that change the program counter take two instruction cycles.
// - Branch: target then branch cycle; prefetched word is flushed, not executed.
// - Core held for start-up count of system clocks chosen by oscillator source.
// - Taken skip discards prefetched word, dummy cycle while correct word fetched.
// - Low program counter byte write jumps in page, inserts one dummy cycle.
`timescale 1ns/1ps
`default_nettype none
module fepipe_top
   import fepipe_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   input wire logic [1:0] osc_source_select,
   output logic [FEPIPE_PC_W-1:0] fetch_address,
   output logic fetch_strobe,
   input wire logic [FEPIPE_INSN_W-1:0] fetch_data,
   output logic [FEPIPE_INSN_W-1:0] exec_word,
   output logic exec_valid,
   output logic [FEPIPE_PHASES-1:0] instruction_phase_clocks,
   output logic [FEPIPE_PC_W-1:0] program_counter,
   output logic core_running,
   input wire logic branch_taken,
   input wire logic [FEPIPE_PC_W-1:0] branch_target,
   input wire logic skip_taken,
   input wire logic program_counter_low_byte_write,
   input wire logic [FEPIPE_PAGE_W-1:0] program_counter_low_byte
);
   typedef struct packed {
      logic [FEPIPE_SST_W-1:0] sst_count;
      logic running;
      logic [FEPIPE_PC_W-1:0] pc;
      logic [FEPIPE_INSN_W-1:0] prefetch;
      logic prefetch_valid;
      logic [FEPIPE_INSN_W-1:0] exec;
      logic exec_ok;
      logic fetch_req;
   } fepipe_state_t;
   fepipe_state_t state;
   fepipe_state_t next_state;
   logic [FEPIPE_PHASES-1:0] phase;
   logic [FEPIPE_SST_W-1:0] sst_limit;
   logic [1:0] src_meta;
   logic [1:0] src_sync;
   logic redirect;

   // Strap may change asynchronously; two flops before use
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         src_meta <= 2'h0;
         src_sync <= 2'h0;
      end else if (clock_enable) begin
         src_meta <= osc_source_select;
         src_sync <= src_meta;
      end
   end

   always_comb begin
      case (fepipe_src_t'(src_sync))
         FEPIPE_SRC_XTAL: sst_limit = FEPIPE_SST_W'(FEPIPE_SST_XTAL);
         FEPIPE_SRC_RC_SHORT: sst_limit = FEPIPE_SST_W'(FEPIPE_SST_RC_SHORT);
         FEPIPE_SRC_RC_LONG: sst_limit = FEPIPE_SST_W'(FEPIPE_SST_RC_LONG);
         default: sst_limit = FEPIPE_SST_W'(FEPIPE_SST_XTAL);
      endcase
   end

   fepipe_phase_gen u_phase (
      .clock(clock),
      .reset_n(reset_n),
      .clock_enable(clock_enable),
      .run(state.running),
      .instruction_phase_clocks(phase)
   );

   // Any change of flow in phase four of a valid execution flushes the prefetch
   assign redirect = state.exec_ok && phase[FEPIPE_PHASES-1]
      && (branch_taken || skip_taken || program_counter_low_byte_write);

   always_comb begin
      next_state = state;
      next_state.fetch_req = 1'b0;
      if (!state.running) begin
         // Hold core until start-up count elapses
         if (state.sst_count >= sst_limit - 1'b1) begin
            next_state.running = 1'b1;
         end else begin
            next_state.sst_count = state.sst_count + 1'b1;
         end
      end else if (phase[0]) begin
         // Request fetch for phase two, overlapped with execution
         next_state.fetch_req = 1'b1;
         next_state.pc = state.pc + 1'b1;
         next_state.exec = state.prefetch;
         next_state.exec_ok = state.prefetch_valid;
      end else if (phase[1]) begin
         next_state.prefetch = fetch_data;
         next_state.prefetch_valid = 1'b1;
      end else if (phase[FEPIPE_PHASES-1]) begin
         // Two-cycle flow change: flushed word becomes dummy cycle
         if (redirect) begin
            next_state.prefetch_valid = 1'b0;
         end
         if (state.exec_ok && branch_taken) begin
            next_state.pc = branch_target;
         end else if (state.exec_ok && program_counter_low_byte_write) begin
            // Jump limited to current page
            next_state.pc = {state.pc[FEPIPE_PC_W-1:FEPIPE_PAGE_W], program_counter_low_byte};
         end
         // Skip keeps incremented pc, so the skipped word is passed over
      end
      // Execute stage in phases two to four
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         // Empty pipeline: first cycle fetches reset vector only
         state.sst_count <= '0;
         state.running <= 1'b0;
         state.pc <= FEPIPE_RESET_VECTOR;
         state.prefetch <= '0;
         state.prefetch_valid <= 1'b0;
         state.exec <= '0;
         state.exec_ok <= 1'b0;
         state.fetch_req <= 1'b0;
      end else if (clock_enable) begin
         state <= next_state;
      end
   end

   assign fetch_address = state.pc - 1'b1;
   assign fetch_strobe = state.fetch_req;
   assign exec_word = state.exec;
   assign exec_valid = state.exec_ok && !phase[0] && state.running;
   assign instruction_phase_clocks = phase;
   assign program_counter = state.pc;
   assign core_running = state.running;
endmodule : fepipe_top
`default_nettype wire

// ==== dv/fepipe_mem_model.sv ====
// Program memory model for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fepipe_mem_model
   import fepipe_pkg::*;
(
   input wire logic [14:0] fetch_address,
   input wire logic fetch_strobe,
   output logic [15:0] fetch_data
);
   // Idle bus shows a moving inverse, so a late sample never passes
   assign fetch_data = fetch_strobe ? {1'b1, fetch_address} : {1'b0, ~fetch_address};
endmodule : fepipe_mem_model
`default_nettype wire

// ==== dv/fepipe_top_assertions.sv ====
// Port checks for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fepipe_top_assertions
   import fepipe_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   input wire logic [14:0] fetch_address,
   input wire logic fetch_strobe,
   input wire logic exec_valid,
   input wire logic [3:0] instruction_phase_clocks,
   input wire logic [14:0] program_counter,
   input wire logic core_running,
   input wire logic branch_taken,
   input wire logic [14:0] branch_target,
   input wire logic skip_taken,
   input wire logic program_counter_low_byte_write,
   input wire logic [7:0] program_counter_low_byte
);
   wire logic [3:0] ph = instruction_phase_clocks;
   wire logic [6:0] hi = program_counter[14:8];
   wire logic fl = ph[3] && exec_valid && clock_enable;
   wire logic pw = program_counter_low_byte_write;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_plain; ph[1] ##2 (ph[3] && !branch_taken && !pw); endsequence
   sequence s_flow; fl && (branch_taken || skip_taken || pw); endsequence
   a_phase_onehot: assert property ($onehot0(ph)) else $error("phase overlap");
   a_phase_order: assert property (ph[0] && clock_enable |=> ph[1] ##1 ph[2] ##1 ph[3])
      else $error("phase order");
   a_held_idle: assert property (!core_running |-> ph == 4'h0) else $error("held");
   a_fetch_addr: assert property (fetch_strobe |-> ph[1] && fetch_address == program_counter - 15'h1)
      else $error("fetch");
   a_pc_step: assert property (s_plain |-> ##2 program_counter == $past(program_counter, 4) + 15'h1)
      else $error("pc step");
   a_branch_load: assert property (fl && branch_taken |=> program_counter == $past(branch_target))
      else $error("branch");
   a_page_jump: assert property (fl && pw && !branch_taken |=>
      program_counter == {$past(hi), $past(program_counter_low_byte)}) else $error("page");
   a_flush_dummy: assert property (s_flow |=> !exec_valid [*4]) else $error("flush");
endmodule : fepipe_top_assertions
`default_nettype wire

// ==== dv/fepipe_top_bench.sv ====
// Bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fepipe_top_bench;
   import fepipe_pkg::*;
   logic clock = 0, reset_n = 0, clock_enable = 1, branch_taken = 0, skip_taken = 0;
   logic program_counter_low_byte_write = 0, fetch_strobe, exec_valid, core_running;
   logic [1:0] osc_source_select = 2'h1;
   logic [7:0] program_counter_low_byte = 8'h40;
   logic [14:0] branch_target = 15'h7FFE, fetch_address, program_counter;
   logic [15:0] fetch_data, exec_word;
   logic [3:0] instruction_phase_clocks;
   int miscompares = 0, checked = 0;
   always #5 clock = ~clock;
   fepipe_top uut (.*);
   fepipe_mem_model mem (.*);
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic wait_ph(int n);
      int i = 0;
      do begin @(negedge clock); i++; end while (instruction_phase_clocks[n] !== 1'b1 && i < 99);
   endtask : wait_ph
   task automatic startup(logic [1:0] sel, int lo);
      int n = 0;
      @(negedge clock);
      reset_n = 0;
      osc_source_select = sel;
      repeat (4) @(negedge clock);
      reset_n = 1;
      // Strap synchroniser adds a few cycles of slack
      while (core_running !== 1'b1 && n < 1100) begin @(negedge clock); n++; end
      cmp("start", 16'h1, 16'(n >= lo && n <= lo + 6));
      wait_ph(1);
      cmp("vector", 16'(FEPIPE_RESET_VECTOR), 16'(fetch_address));
      cmp("idle", 16'h0, 16'(exec_valid));
   endtask : startup
   task automatic run_seq();
      logic [14:0] a;
      repeat (3) begin
         a = fetch_address;
         cmp("strobe", 16'h1, 16'(fetch_strobe));
         wait_ph(1);
         cmp("next", 16'(a + 15'h1), 16'(fetch_address));
         cmp("exec", {1'b1, a}, exec_word);
         cmp("valid", 16'h1, 16'(exec_valid));
      end
   endtask : run_seq
   task automatic flow(int kind, logic [14:0] exp);
      wait_ph(3);
      branch_taken = (kind == 0);
      skip_taken = (kind == 1);
      program_counter_low_byte_write = (kind == 2);
      @(negedge clock);
      {branch_taken, skip_taken, program_counter_low_byte_write} = 3'h0;
      wait_ph(1);
      cmp("flush", 16'h0, 16'(exec_valid));
      cmp("target", 16'(exp), 16'(fetch_address));
      wait_ph(1);
      cmp("resume", {1'b1, exp}, exec_word);
   endtask : flow
   task automatic freeze_check();
      @(negedge clock);
      reset_n = 0;
      osc_source_select = 2'h1;
      repeat (4) @(negedge clock);
      reset_n = 1;
      // Enable low must stall the start-up count as well
      clock_enable = 0;
      repeat (6) @(negedge clock);
      cmp("frozen", 16'h0, 16'(core_running));
      clock_enable = 1;
      repeat (3) @(negedge clock);
      cmp("thawed", 16'h1, 16'(core_running));
   endtask : freeze_check
   task automatic print_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      startup(2'h1, FEPIPE_SST_RC_SHORT);
      run_seq();
      flow(0, 15'h7FFE);
      flow(1, program_counter);
      flow(2, {program_counter[14:8], 8'h40});
      freeze_check();
      startup(2'h0, FEPIPE_SST_XTAL);
      startup(2'h2, FEPIPE_SST_RC_LONG);
      run_seq();
      print_verdict();
   end
   initial begin
      #60us;
      miscompares++;
      print_verdict();
   end
endmodule : fepipe_top_bench
bind fepipe_top fepipe_top_assertions chk (.*);
`default_nettype wire
